//--- src/pcrs_pkg.sv
//==============================================================================
// Platform clock ratio strap constants
//==============================================================================
package pcrs_pkg;

    // Strap and ratio widths
    localparam int STRAP_W = 4;
    localparam int RATIO_W = 5;

    // Synchroniser depth ahead of the capture logic
    localparam int SYNC_STAGES = 2;

    // Settle counter width and the count at which the strap is captured
    localparam int              SETTLE_W    = 2;
    localparam logic [1:0]      SETTLE_LAST = 2'h2;

    // Memory bus clock runs at platform rate divided by this
    localparam logic [RATIO_W-1:0] MEM_BUS_DIVIDE = 5'h02;

    // Values after reset
    localparam logic [STRAP_W-1:0] STRAP_RESET = 4'h0;
    localparam logic [RATIO_W-1:0] RATIO_RESET = 5'h00;

    // Ratio code for any reserved strap value
    localparam logic [RATIO_W-1:0] RATIO_NONE = 5'h00;

    // Strap code to platform ratio, indexed by the strap code
    localparam logic [RATIO_W-1:0] RATIO_TABLE [16] = '{
        5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00,
        5'h08, 5'h09, 5'h0A, 5'h00, 5'h0C, 5'h14, 5'h00, 5'h00
    };

    // Reserved strap codes, one bit per code, bit index equals code
    localparam logic [15:0] STRAP_RESERVED_MASK = 16'hC882;

    // Capture sequencing
    typedef enum logic {
        PCRS_WAIT,
        PCRS_HOLD
    } pcrs_phase_t;

endpackage : pcrs_pkg

//--- src/pcrs_sync.sv
`timescale 1ns/100ps
`default_nettype none
//==============================================================================
// Two flip-flop synchroniser for the strap lines
//==============================================================================
module pcrs_sync (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic [pcrs_pkg::STRAP_W-1:0] d_in,
    output var  logic [pcrs_pkg::STRAP_W-1:0] q_out
);
    import pcrs_pkg::*;

    // Both stages in one state record
    typedef struct packed {
        logic [STRAP_W-1:0] meta;   // First stage, read only by the second
        logic [STRAP_W-1:0] safe;   // Second stage, safe to decode
    } pcrs_sync_state_t;

    pcrs_sync_state_t state_reg;
    pcrs_sync_state_t state_next;

    //==========================================================================
    // Next state
    //==========================================================================
    always_comb begin
        state_next      = state_reg;
        state_next.meta = d_in;
        state_next.safe = state_reg.meta;
    end

    //==========================================================================
    // Registers
    //==========================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '{meta: STRAP_RESET, safe: STRAP_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign q_out = state_reg.safe;

endmodule : pcrs_sync
`default_nettype wire

//--- src/pcrs_top.sv
`timescale 1ns/100ps
`default_nettype none
module pcrs_top (
    input  wire logic                         CLK,
    input  wire logic                         RST_N,
    input  wire logic [pcrs_pkg::STRAP_W-1:0] RATIO_STRAP_LINES,
    input  wire logic                         PLATFORM_TICK,
    output var  logic [pcrs_pkg::STRAP_W-1:0] STRAP_CODE,
    output var  logic [pcrs_pkg::RATIO_W-1:0] PLATFORM_RATIO,
    output var  logic [pcrs_pkg::RATIO_W-1:0] MEM_BUS_DIVIDER,
    output var  logic                         RATIO_VALID,
    output var  logic                         STRAP_INVALID,
    output var  logic                         MEM_BUS_TICK
);
    import pcrs_pkg::*;

    //==========================================================================
    // State record
    //==========================================================================
    typedef struct packed {
        pcrs_phase_t         phase;     // Waiting for strap or holding it
        logic [SETTLE_W-1:0] settle;    // Cycles since reset release
        logic [STRAP_W-1:0]  code;      // Captured strap code
        logic [RATIO_W-1:0]  ratio;     // Platform to reference multiplier
        logic [RATIO_W-1:0]  mem_div;   // Memory bus divider
        logic                valid;     // Captured code is a legal ratio
        logic                invalid;   // Captured code is reserved
        logic                mem_phase; // Odd platform tick seen
        logic                mem_tick;  // Memory bus clock enable
    } pcrs_state_t;

    pcrs_state_t        state_reg;
    pcrs_state_t        state_next;
    logic [STRAP_W-1:0] strap_safe;     // Synchronised strap lines

    //==========================================================================
    // Strap synchroniser; straps come from board pins, not this clock
    //==========================================================================
    pcrs_sync u_sync (
        .clk   (CLK),
        .rst_n (RST_N),
        .d_in  (RATIO_STRAP_LINES),
        .q_out (strap_safe)
    );

    //==========================================================================
    // Next state
    //==========================================================================
    always_comb begin
        state_next          = state_reg;
        state_next.mem_tick = 1'b0;
        unique case (state_reg.phase)
            // Let the synchroniser fill before trusting the strap
            PCRS_WAIT: begin
                if (state_reg.settle == SETTLE_LAST) begin
                    // One-time capture; the table decides the ratio
                    state_next.phase   = PCRS_HOLD;
                    state_next.code    = strap_safe;
                    state_next.ratio   = RATIO_TABLE[strap_safe];
                    state_next.invalid = STRAP_RESERVED_MASK[strap_safe];
                    state_next.valid   = !STRAP_RESERVED_MASK[strap_safe];
                    state_next.mem_div = MEM_BUS_DIVIDE;
                end else begin
                    state_next.settle = state_reg.settle + 2'h1;
                end
            end
            // Strap held until the next reset; later pin changes ignored
            PCRS_HOLD: begin
                // No memory clock from a reserved strap: nothing is safe to run
                if (state_reg.valid && PLATFORM_TICK) begin
                    state_next.mem_phase = !state_reg.mem_phase;
                    state_next.mem_tick  = state_reg.mem_phase;
                end
            end
        endcase
    end

    //==========================================================================
    // Registers
    //==========================================================================
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= '{phase: PCRS_WAIT, settle: '0, code: STRAP_RESET,
                           ratio: RATIO_RESET, mem_div: RATIO_RESET, valid: 1'b0,
                           invalid: 1'b0, mem_phase: 1'b0, mem_tick: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state flops
    assign STRAP_CODE      = state_reg.code;
    assign PLATFORM_RATIO  = state_reg.ratio;
    assign MEM_BUS_DIVIDER = state_reg.mem_div;
    assign RATIO_VALID     = state_reg.valid;
    assign STRAP_INVALID   = state_reg.invalid;
    assign MEM_BUS_TICK    = state_reg.mem_tick;

    //==========================================================================
    // Checks
    //==========================================================================
    logic [3:0] since_rst;      // Saturating count of cycles since release
    logic [1:0] plat_seen;      // Platform ticks since last memory tick

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            since_rst <= 4'h0;
            plat_seen <= 2'h0;
        end else begin
            if (since_rst != 4'hF) begin
                since_rst <= since_rst + 4'h1;
            end
            if (MEM_BUS_TICK) begin
                plat_seen <= {1'b0, PLATFORM_TICK && RATIO_VALID};
            end else if (PLATFORM_TICK && RATIO_VALID && plat_seen != 2'h3) begin
                plat_seen <= plat_seen + 2'h1;
            end
        end
    end

    sequence s_captured;
        RATIO_VALID || STRAP_INVALID;
    endsequence

    a_ratio_decode: assert property (@(posedge CLK) disable iff (!RST_N)
        RATIO_VALID |-> PLATFORM_RATIO == RATIO_TABLE[STRAP_CODE] && PLATFORM_RATIO != RATIO_NONE)
        else $error("Platform ratio does not match strap code");

    a_reserved_flag: assert property (@(posedge CLK) disable iff (!RST_N)
        s_captured |-> STRAP_INVALID == STRAP_RESERVED_MASK[STRAP_CODE] && RATIO_VALID != STRAP_INVALID)
        else $error("Reserved strap flag wrong");

    a_capture_time: assert property (@(posedge CLK) disable iff (!RST_N)
        (since_rst >= 4'h3) == (RATIO_VALID || STRAP_INVALID))
        else $error("Strap not captured exactly three edges after reset");

    a_code_held: assert property (@(posedge CLK) disable iff (!RST_N)
        s_captured ##1 s_captured |-> $stable(STRAP_CODE) && $stable(PLATFORM_RATIO))
        else $error("Captured strap changed before reset");

    a_code_source: assert property (@(posedge CLK) disable iff (!RST_N)
        since_rst == 4'h2 ##1 s_captured |-> STRAP_CODE == $past(strap_safe))
        else $error("Captured code is not the synchronised strap");

    a_mem_half: assert property (@(posedge CLK) disable iff (!RST_N)
        MEM_BUS_TICK |-> plat_seen == 2'h2 && MEM_BUS_DIVIDER == MEM_BUS_DIVIDE)
        else $error("Memory bus tick not every second platform tick");

    a_mem_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
        !RATIO_VALID |-> !MEM_BUS_TICK)
        else $error("Memory bus tick without valid ratio");

endmodule : pcrs_top
`default_nettype wire

//--- sim/pcrs_board.sv
`timescale 1ns/100ps
`default_nettype none
//==============================================================================
// Board strap pull network
//==============================================================================
module pcrs_board (
    input  wire logic [pcrs_pkg::STRAP_W-1:0] code_in,
    output var  logic [pcrs_pkg::STRAP_W-1:0] strap_out
);
    import pcrs_pkg::*;

    // Every line is pulled to a firm level, there is no floating default.
    // The code stands for a board whose reference clock keeps the platform
    // clock at the memory data rate, at or above its floor, and the memory
    // bus clock inside its window; the decoder itself cannot see frequencies.
    always_comb begin
        strap_out = code_in;
    end
endmodule : pcrs_board
`default_nettype wire

//--- sim/pcrs_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
//==============================================================================
// Bench for the strap decoder
//==============================================================================
module pcrs_top_tb_top;
    import pcrs_pkg::*;

    logic               clk, rst_n, tick;      // Clock, reset, platform enable
    logic [STRAP_W-1:0] code;                   // Code the board presents
    logic [STRAP_W-1:0] strap, s_code;          // Pins and captured code
    logic [RATIO_W-1:0] ratio, divider;         // Decoded outputs
    logic               valid, invalid, m_tick; // Status and memory enable
    logic [31:0]        seed;                   // Xorshift state
    int                 n_mismatch, n_compared; // Verdict counters

    pcrs_board i_board (.code_in(code), .strap_out(strap));

    pcrs_top i_dut (
        .CLK(clk), .RST_N(rst_n), .RATIO_STRAP_LINES(strap), .PLATFORM_TICK(tick),
        .STRAP_CODE(s_code), .PLATFORM_RATIO(ratio), .MEM_BUS_DIVIDER(divider),
        .RATIO_VALID(valid), .STRAP_INVALID(invalid), .MEM_BUS_TICK(m_tick)
    );

    //==========================================================================
    // Helpers
    //==========================================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // Reference ratio per strap code, zero where the code is reserved
    function automatic int ref_ratio(input int c);
        if (c == 0) return 16;
        if (c inside {[2:6], [8:10], 12}) return c;
        if (c == 13) return 20;
        return 0;
    endfunction : ref_ratio

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    //==========================================================================
    // Clock and watchdog
    //==========================================================================
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Whole run needs about 360 cycles; this leaves wide margin
    initial begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end

    //==========================================================================
    // Every strap code: reset, capture, later strap noise, random ticks
    //==========================================================================
    initial begin
        int  cnt, er;
        bit  rsv, vld, t_cur, exp_t;
        rst_n = 1'b0;
        tick = 1'b0;
        code = 4'h0;
        seed = 32'had161be7;
        n_mismatch = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            rst_n <= 1'b0;
            tick <= 1'b0;
            code <= c[3:0];
            t_cur = 1'b0;
            cnt = 0;
            er = ref_ratio(c);
            rsv = c inside {1, 7, 11, 14, 15};
            #1;
            chk("reset valid", valid, 32'h0);
            @(posedge clk);
            rst_n <= 1'b1;
            for (int i = 1; i <= 20; i++) begin
                @(posedge clk);
                exp_t = 1'b0;
                // Ticks count only once a legal code has been captured
                if (t_cur && i >= 4 && !rsv) begin
                    cnt++;
                    exp_t = (cnt % 2 == 0);
                end
                seed = xs(seed);
                t_cur = seed[0];
                tick <= t_cur;
                // Strap may wander once the capture edge has passed
                if (i >= 3) code <= seed[7:4];
                vld = (i >= 3);
                #1;
                chk("mem tick", m_tick, exp_t);
                chk("strap code", s_code, vld ? c : 0);
                chk("ratio", ratio, vld ? er : 0);
                chk("valid", valid, vld && !rsv);
                chk("invalid", invalid, vld && rsv);
                chk("divider", divider, vld ? 2 : 0);
            end
        end
        report_and_stop();
    end
endmodule : pcrs_top_tb_top
`default_nettype wire
